// File: tb_tcfg_conv_sched.sv
// Compare with count and one-line report
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_tcfg_conv_sched
  import tcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int FAST = 20; // Short conversion count
  localparam int SLOW = 30; // Long conversion count
  localparam int BASE = 200; // Period at eight per second

  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regPtr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic localEn = 1'b1;
  logic remote1En = 1'b1;
  logic remote2En = 1'b1;
  logic shutdown = 1'b0;
  logic useDiode = 1'b0; // Partner reports diode connection
  logic [2:0] pickRange = 3'h0; // Partner range answer
  logic [3:0] delayCyc = 4'h1; // Partner answer delay
  wire logic [7:0] regRdata;
  wire logic regRvalid;
  wire logic detValid;
  wire logic detDiode;
  wire logic [2:0] detRange;
  wire logic convDetect;
  wire logic convStart;
  wire logic [1:0] convChannel;
  wire logic convDiodeMode;
  wire logic [2:0] convBetaRange;
  wire logic [19:0] convIdeality;
  wire logic convBusy;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0; // Free-running cycle count
  int tStart; // Cycle of the last awaited start
  logic other; // Another channel started meanwhile
  logic sawDet; // Detection seen meanwhile

  tcfg_conv_sched #(.DUAL_REMOTE(1'b1), .CONV_FAST_CYC(FAST), .CONV_SLOW_CYC(SLOW),
    .RATE_BASE_CYC(BASE)) dut (.core_clk(core_clk), .reset_n(reset_n),
    .regWrite(regWrite), .regRead(regRead), .regPtr(regPtr), .regWdata(regWdata),
    .regRdata(regRdata), .regRvalid(regRvalid), .localEn(localEn),
    .remote1En(remote1En), .remote2En(remote2En), .shutdown(shutdown),
    .detValid(detValid), .detDiode(detDiode), .detRange(detRange),
    .convDetect(convDetect), .convStart(convStart), .convChannel(convChannel),
    .convDiodeMode(convDiodeMode), .convBetaRange(convBetaRange),
    .convIdeality(convIdeality), .convBusy(convBusy));

  tcfg_sensor_model partner (.core_clk(core_clk), .reset_n(reset_n),
    .convDetect(convDetect), .useDiode(useDiode), .pickRange(pickRange),
    .delayCyc(delayCyc), .detValid(detValid), .detDiode(detDiode), .detRange(detRange));

  // Clock and cycle count
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc++;

  // Verdict and end of run
  task automatic stop_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One register write
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regPtr <= p;
    regWdata <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask

  // One register read, answer compared
  task automatic rchk(input logic [7:0] p, input logic [7:0] e);
    @(posedge core_clk);
    regRead <= 1'b1;
    regPtr <= p;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    `CHK(regRvalid, 1'b1)
    `CHK(regRdata, e)
  endtask

  // Wait for a conversion start on one channel, bounded
  task automatic wait_start(input logic [1:0] ch);
    other = 1'b0;
    sawDet = 1'b0;
    for (int i = 0; i < 40000; i++) begin
      @(posedge core_clk);
      #1;
      if (convDetect === 1'b1) sawDet = 1'b1;
      if (convStart === 1'b1 && convChannel === ch) begin
        tStart = cyc;
        return;
      end
      if (convStart === 1'b1) other = 1'b1;
    end
    n_fail++;
    stop_test();
  endtask

  // Expected effective ideality, Q4.16
  function automatic logic [19:0] exp_ideal(input bit b, input logic [7:0] a);
    longint n;
    longint dd;
    n = longint'(b ? 1008 : 1000) * 300 * 65536;
    dd = (300 - longint'($signed(a))) * 1000;
    return 20'(n / dd);
  endfunction

  // Main sequence
  initial begin
    int t0, gap, gRef, gFast, ex;
    logic [7:0] v;
    logic b;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    // Power-on values and refused accesses
    rchk(8'h30, 8'h08);
    rchk(8'h04, 8'h07);
    rchk(8'h28, 8'h00);
    rchk(8'h0a, 8'h00);
    wr(8'h18, 8'h55);
    rchk(8'h18, 8'h00);
    wr(8'h31, 8'h00);
    // Beta codes 0-8, auto ranges and diode detection on remote 1
    for (int k = 0; k < 17; k++) begin
      @(posedge core_clk);
      useDiode <= (k == 16);
      pickRange <= 3'(k - 8);
      delayCyc <= 4'(k);
      wr(8'h30, (k < 8) ? 8'(k) : 8'h08);
      b = (k == 7 || k == 16);
      wait_start(CH_LOCAL);
      wait_start(CH_REM1);
      `CHK(other, 1'b0)
      `CHK(sawDet, (k >= 8))
      `CHK(convDiodeMode, b)
      `CHK(convIdeality, exp_ideal(b, 8'h00))
      if (k != 7) `CHK(convBetaRange, 3'((k < 8) ? k : k - 8))
      t0 = tStart;
      wait_start(CH_REM2);
      `CHK(other, 1'b0)
      gap = tStart - t0;
      if (k == 0) gFast = gap;
      `CHK(gap, gFast + ((k >= 8 && k < 16) ? SLOW - FAST : 0))
      rchk(8'h30, (k == 16) ? 8'h0f : 8'(k));
    end
    // Signed adjust values with diode base
    wr(8'h30, 8'h07);
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : (i == 2) ? 8'h0a : (i == 3) ? 8'hf6 : 8'h00;
      wr(8'h28, v);
      rchk(8'h28, v);
      wait_start(CH_LOCAL);
      wait_start(CH_REM1);
      `CHK(convIdeality, exp_ideal(1'b1, v))
    end
    // Disabled channels are skipped
    @(posedge core_clk);
    remote1En <= 1'b0;
    wait_start(CH_LOCAL);
    wait_start(CH_REM2);
    `CHK(other, 1'b0)
    @(posedge core_clk);
    remote1En <= 1'b1;
    localEn <= 1'b0;
    remote2En <= 1'b0;
    wait_start(CH_REM1);
    wait_start(CH_REM1);
    `CHK(other, 1'b0)
    @(posedge core_clk);
    localEn <= 1'b1;
    remote2En <= 1'b1;
    // Shutdown holds the sequencer in delay
    wait_start(CH_LOCAL);
    @(posedge core_clk);
    shutdown <= 1'b1;
    b = 1'b0;
    repeat (700) begin
      @(posedge core_clk);
      #1;
      if (convStart === 1'b1 && convChannel === CH_LOCAL) b = 1'b1;
    end
    `CHK(b, 1'b0)
    `CHK(convBusy, 1'b0)
    @(posedge core_clk);
    shutdown <= 1'b0;
    // Rate codes: period from code, conversion timing unchanged
    for (int i = 0; i < 7; i++) begin
      v = (i == 0) ? 8'h0f : 8'(8 - i);
      wr(8'h0a, v);
      rchk(8'h04, v);
      ex = (v >= 8'h07) ? BASE : BASE << (7 - v);
      wait_start(CH_LOCAL);
      wait_start(CH_LOCAL);
      t0 = tStart;
      wait_start(CH_REM1);
      gap = tStart - t0;
      if (i == 0) gRef = gap;
      `CHK(gap, gRef)
      wait_start(CH_LOCAL);
      `CHK(tStart - t0, ex)
    end
    // Second reset restores defaults
    wr(8'h28, 8'h55);
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    rchk(8'h04, 8'h07);
    rchk(8'h28, 8'h00);
    stop_test();
  end
endmodule

// File: tcfg_beta_if.sv
// Beta setting of the channel in work and its resolved meaning
interface tcfg_beta_if;
  logic [3:0] setting; // Stored beta field
  logic detDiode; // Front end found diode connection
  logic [2:0] detRange; // Front end picked range
  logic autoMode; // Detection requested
  logic diodeMode; // Measure as diode, base 1.008
  logic slowConv; // Long conversion needed
  logic base1008; // Base factor select
  logic [2:0] range; // Range handed to front end
  logic [3:0] readback; // Value software reads back
  modport owner(output setting, detDiode, detRange,
                input autoMode, diodeMode, slowConv, base1008, range, readback);
  modport resolver(input setting, detDiode, detRange,
                   output autoMode, diodeMode, slowConv, base1008, range, readback);
endinterface

// File: tcfg_beta_resolve.sv
`include "tcfg_consts.svh"

module tcfg_beta_resolve
  import tcfg_pkg::*;
(
  tcfg_beta_if.resolver bif
);
  // Decode the beta field against the detection result
  always_comb begin
    bif.autoMode = bif.setting[`TCFG_BETA_AUTO_BIT];
    bif.diodeMode = (bif.setting == `TCFG_BETA_OFF) || (bif.autoMode && bif.detDiode);
    bif.slowConv = bif.autoMode && !bif.detDiode;
    bif.base1008 = bif.diodeMode;
    bif.range = bif.autoMode ? bif.detRange : bif.setting[2:0];
    if (!bif.autoMode) begin
      bif.readback = bif.setting;
    end else if (bif.detDiode) begin
      bif.readback = `TCFG_BETA_DIODE_RB;
    end else begin
      bif.readback = {1'b1, bif.detRange};
    end
  end
endmodule

// File: tcfg_consts.svh
`ifndef TCFG_CONSTS_SVH
`define TCFG_CONSTS_SVH

// Pointer addresses on the host port
`define TCFG_PTR_RATE_RD 8'h04
`define TCFG_PTR_RATE_WR 8'h0a
`define TCFG_PTR_ETA_SINGLE 8'h18
`define TCFG_PTR_ETA_DUAL 8'h28
`define TCFG_PTR_BETA1 8'h30
`define TCFG_PTR_BETA2 8'h31

// Power-on values
`define TCFG_RATE_POR 8'h07
`define TCFG_ETA_POR 8'h00
`define TCFG_BETA_POR 4'h8
`define TCFG_RDATA_IDLE 8'h00

// Rate code decode
`define TCFG_RATE_FAST_CODE 8'h07
`define TCFG_RATE_MAX_SHIFT 3'd7

// Beta field codes
`define TCFG_BETA_OFF 4'h7
`define TCFG_BETA_DIODE_RB 4'hf
`define TCFG_BETA_AUTO_BIT 3

// Ideality arithmetic
`define TCFG_ETA_SCALE 300
`define TCFG_MILLI 1000
`define TCFG_BASE_DIODE_MILLI 1008
`define TCFG_BASE_GND_MILLI 1000
`define TCFG_IDEAL_FRAC 16

// Timing: figures in ms, counts derived at the core clock rate
`define TCFG_CLK_HZ 40000000
`define TCFG_CONV_FAST_MS 93
`define TCFG_CONV_SLOW_MS 126
`define TCFG_RATE_BASE_MS 125
`define TCFG_CONV_FAST_CYC (`TCFG_CONV_FAST_MS * (`TCFG_CLK_HZ / `TCFG_MILLI))
`define TCFG_CONV_SLOW_CYC (`TCFG_CONV_SLOW_MS * (`TCFG_CLK_HZ / `TCFG_MILLI))
`define TCFG_RATE_BASE_CYC (`TCFG_RATE_BASE_MS * (`TCFG_CLK_HZ / `TCFG_MILLI))

`endif

// File: tcfg_conv_sched.sv
// Behaviour
// - rate written 0Ah, read 04h, resets 07h
// - rate sets only the period from one sequence start to the next
// - codes 0-6 slow rates, 07h-0Fh eight/second
// - top beta bit set runs connection detection
// - code 0111 skips detection, diode, no beta
// - ideality 1.008 when disabled or diode found
// - ideality 1.000 for auto with grounded collector
// - auto read-back 1000-1111, 126 ms; diode 1111, 93 ms
// - codes 0000-0110 force manual range, 93 ms
// - eta adjust is signed eight-bit two's complement
// - ideality equals base times 300 over 300-adjust
// - eta at 18h single, 28h dual variant
// - eta resets to zero, no effect
// - local, remote1, remote2, then delay; skip disabled
`include "tcfg_consts.svh"

module tcfg_conv_sched
  import tcfg_pkg::*;
#(
  parameter bit DUAL_REMOTE = 1'b1,
  parameter int unsigned CONV_FAST_CYC = `TCFG_CONV_FAST_CYC,
  parameter int unsigned CONV_SLOW_CYC = `TCFG_CONV_SLOW_CYC,
  parameter int unsigned RATE_BASE_CYC = `TCFG_RATE_BASE_CYC
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regPtr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic regRvalid,
  input wire logic localEn,
  input wire logic remote1En,
  input wire logic remote2En,
  input wire logic shutdown,
  input wire logic detValid,
  input wire logic detDiode,
  input wire logic [2:0] detRange,
  output logic convDetect,
  output logic convStart,
  output logic [1:0] convChannel,
  output logic convDiodeMode,
  output logic [2:0] convBetaRange,
  output logic [19:0] convIdeality,
  output logic convBusy
);
  localparam logic [7:0] ETA_PTR = DUAL_REMOTE ? `TCFG_PTR_ETA_DUAL : `TCFG_PTR_ETA_SINGLE;

  // Register file
  logic [7:0] convRate; // Rate code
  logic [7:0] etaAdj; // Signed ideality adjust
  logic [3:0] betaSet [2]; // Beta field per remote
  logic [7:0] next_convRate;
  logic [7:0] next_etaAdj;
  logic [3:0] next_betaSet [2];
  logic [7:0] next_regRdata;
  logic next_regRvalid;

  // Sequencer state
  tcfg_state_t state;
  tcfg_state_t next_state;
  logic [1:0] chIdx; // Channel under consideration
  logic [1:0] next_chIdx;
  logic [31:0] convCnt; // Cycles left in conversion
  logic [31:0] next_convCnt;
  logic [3:0] betaRead [2]; // Last resolved read-back
  logic [3:0] next_betaRead [2];
  logic next_convStart;
  logic [1:0] next_convChannel;
  logic next_convDiodeMode;
  logic [2:0] next_convBetaRange;
  logic [19:0] next_convIdeality;
  logic seqStart; // Rate period restarts
  logic rateDone; // Rate period elapsed
  logic launch; // Begin a measurement now
  logic isRemote; // Slot is a remote channel
  logic chanOn; // Slot enabled
  logic remIdx; // Remote index of the slot

  tcfg_beta_if bif();

  tcfg_beta_resolve u_resolve (
    .bif(bif)
  );

  tcfg_rate_timer #(
    .RATE_BASE_CYC(RATE_BASE_CYC)
  ) u_rate (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .start(seqStart),
    .rateCode(convRate),
    .done(rateDone)
  );

  // Feed the resolver the slot's setting and live detection
  assign remIdx = (chIdx == CH_REM2);
  assign bif.setting = betaSet[remIdx];
  assign bif.detDiode = detDiode;
  assign bif.detRange = detRange;

  // Host writes and registered read answers
  always_comb begin
    next_convRate = convRate;
    next_etaAdj = etaAdj;
    next_betaSet = betaSet;
    next_regRdata = regRdata;
    next_regRvalid = regRead;
    if (regWrite) begin
      if (regPtr == `TCFG_PTR_RATE_WR) begin
        next_convRate = regWdata;
      end
      if (regPtr == ETA_PTR) begin
        next_etaAdj = regWdata;
      end
      if (regPtr == `TCFG_PTR_BETA1) begin
        next_betaSet[0] = regWdata[3:0];
      end
      if (regPtr == `TCFG_PTR_BETA2) begin
        next_betaSet[1] = regWdata[3:0];
      end
    end
    if (regRead) begin
      unique case (regPtr)
        `TCFG_PTR_RATE_RD: next_regRdata = convRate;
        ETA_PTR: next_regRdata = etaAdj;
        `TCFG_PTR_BETA1: next_regRdata = {4'h0, betaSet[0][3] ? betaRead[0] : betaSet[0]};
        `TCFG_PTR_BETA2: next_regRdata = {4'h0, betaSet[1][3] ? betaRead[1] : betaSet[1]};
        default: next_regRdata = `TCFG_RDATA_IDLE;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      convRate <= `TCFG_RATE_POR;
      etaAdj <= `TCFG_ETA_POR;
      betaSet[0] <= `TCFG_BETA_POR;
      betaSet[1] <= `TCFG_BETA_POR;
      regRdata <= `TCFG_RDATA_IDLE;
      regRvalid <= 1'b0;
    end else begin
      convRate <= next_convRate;
      etaAdj <= next_etaAdj;
      betaSet <= next_betaSet;
      regRdata <= next_regRdata;
      regRvalid <= next_regRvalid;
    end
  end

  // Slot decode for the sequence
  always_comb begin
    isRemote = (chIdx == CH_REM1) || (chIdx == CH_REM2);
    unique case (chIdx)
      CH_LOCAL: chanOn = localEn;
      CH_REM1: chanOn = remote1En;
      CH_REM2: chanOn = remote2En && DUAL_REMOTE;
      CH_END: chanOn = 1'b0;
    endcase
  end

  // Conversion sequencer
  always_comb begin
    next_state = state;
    next_chIdx = chIdx;
    next_convCnt = convCnt;
    next_betaRead = betaRead;
    next_convStart = 1'b0;
    next_convChannel = convChannel;
    next_convDiodeMode = convDiodeMode;
    next_convBetaRange = convBetaRange;
    next_convIdeality = convIdeality;
    seqStart = 1'b0;
    launch = 1'b0;
    unique case (state)
      ST_DELAY: begin
        if (rateDone && !shutdown) begin
          seqStart = 1'b1;
          next_chIdx = CH_LOCAL;
          next_state = ST_PICK;
        end
      end
      ST_PICK: begin
        if (chIdx == CH_END) begin
          next_state = ST_DELAY;
        end else if (!chanOn) begin
          next_chIdx = 2'(chIdx + 2'h1);
        end else if (isRemote && bif.autoMode) begin
          next_state = ST_DETECT;
        end else begin
          launch = 1'b1;
        end
      end
      ST_DETECT: begin
        if (detValid) begin
          next_betaRead[remIdx] = bif.readback;
          launch = 1'b1;
        end
      end
      ST_CONVERT: begin
        if (convCnt == 32'h1) begin
          next_chIdx = 2'(chIdx + 2'h1);
          next_state = ST_PICK;
        end else begin
          next_convCnt = convCnt - 32'h1;
        end
      end
    endcase
    if (launch) begin
      next_state = ST_CONVERT;
      next_convStart = 1'b1;
      next_convChannel = chIdx;
      next_convCnt = (isRemote && bif.slowConv) ? 32'(CONV_SLOW_CYC) : 32'(CONV_FAST_CYC);
      next_convDiodeMode = isRemote && bif.diodeMode;
      next_convBetaRange = bif.range;
      next_convIdeality = tcfg_eff_ideality(!isRemote || bif.base1008, etaAdj);
    end
  end

  // Sequencer flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_DELAY;
      chIdx <= CH_LOCAL;
      convCnt <= 32'h0;
      betaRead[0] <= `TCFG_BETA_POR;
      betaRead[1] <= `TCFG_BETA_POR;
      convStart <= 1'b0;
      convChannel <= CH_LOCAL;
      convDiodeMode <= 1'b0;
      convBetaRange <= 3'h0;
      convIdeality <= 20'h0;
    end else begin
      state <= next_state;
      chIdx <= next_chIdx;
      convCnt <= next_convCnt;
      betaRead <= next_betaRead;
      convStart <= next_convStart;
      convChannel <= next_convChannel;
      convDiodeMode <= next_convDiodeMode;
      convBetaRange <= next_convBetaRange;
      convIdeality <= next_convIdeality;
    end
  end

  assign convDetect = (state == ST_DETECT);
  assign convBusy = (state != ST_DELAY);

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_rate_rd;
    regRead && regPtr == `TCFG_PTR_RATE_RD |=> regRvalid && regRdata == $past(convRate);
  endproperty
  a_rate_rd: assert property (p_rate_rd) else $error("rate read-back wrong");

  property p_rate_wr;
    regWrite && regPtr == `TCFG_PTR_RATE_WR |=> ##1 regRead && regPtr == `TCFG_PTR_RATE_RD
      |=> regRdata == $past(regWdata, 3);
  endproperty
  a_rate_wr: assert property (p_rate_wr) else $error("rate write lost");

  property p_eta_rw;
    regWrite && regPtr == ETA_PTR ##2 regRead && regPtr == ETA_PTR
      |=> regRdata == $past(regWdata, 3);
  endproperty
  a_eta_rw: assert property (p_eta_rw) else $error("eta write lost");

  property p_conv_len;
    convStart |-> convCnt == 32'(CONV_FAST_CYC) || convCnt == 32'(CONV_SLOW_CYC);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_detect_auto;
    convDetect |-> bif.autoMode && isRemote;
  endproperty
  a_detect_auto: assert property (p_detect_auto) else $error("detect without auto");

  property p_manual_fast;
    state == ST_PICK && chanOn && isRemote && !bif.autoMode
      |=> convStart && convCnt == 32'(CONV_FAST_CYC);
  endproperty
  a_manual_fast: assert property (p_manual_fast) else $error("manual not 93 ms");

  property p_diode_eta;
    convStart && convDiodeMode |-> convIdeality == tcfg_eff_ideality(1'b1, etaAdj);
  endproperty
  a_diode_eta: assert property (p_diode_eta) else $error("diode ideality wrong");

  property p_gnd_eta;
    state == ST_DETECT && detValid && !detDiode
      |=> convIdeality == tcfg_eff_ideality(1'b0, etaAdj) && convCnt == 32'(CONV_SLOW_CYC);
  endproperty
  a_gnd_eta: assert property (p_gnd_eta) else $error("grounded ideality wrong");

  property p_diode_rb;
    state == ST_DETECT && detValid && detDiode |=> betaRead[$past(remIdx)] == `TCFG_BETA_DIODE_RB;
  endproperty
  a_diode_rb: assert property (p_diode_rb) else $error("diode read-back wrong");

  property p_skip;
    convStart |-> (convChannel == CH_LOCAL && localEn) || (convChannel == CH_REM1 && remote1En)
      || (convChannel == CH_REM2 && remote2En);
  endproperty
  a_skip: assert property (p_skip) else $error("disabled channel converted");

  c_diode: cover property (state == ST_DETECT && detValid && detDiode);
  c_manual: cover property (convStart && convChannel != CH_LOCAL && !convDiodeMode);
  c_full_seq: cover property (convStart && convChannel == CH_REM2);
endmodule

// File: tcfg_pkg.sv
`include "tcfg_consts.svh"

package tcfg_pkg;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_DELAY = 2'b00,
    ST_PICK = 2'b01,
    ST_DETECT = 2'b10,
    ST_CONVERT = 2'b11
  } tcfg_state_t;

  // Channel slots in sequence order
  typedef enum logic [1:0] {
    CH_LOCAL = 2'b00,
    CH_REM1 = 2'b01,
    CH_REM2 = 2'b10,
    CH_END = 2'b11
  } tcfg_chan_t;

  // Effective ideality, Q4.16: base * 300 / (300 - adjust)
  function automatic logic [19:0] tcfg_eff_ideality(input logic base1008,
                                                    input logic [7:0] adj);
    logic [39:0] num;
    logic [39:0] den;
    num = 40'(base1008 ? `TCFG_BASE_DIODE_MILLI : `TCFG_BASE_GND_MILLI);
    num = (num * 40'(`TCFG_ETA_SCALE)) << `TCFG_IDEAL_FRAC;
    den = 40'(`TCFG_ETA_SCALE - int'($signed(adj))) * 40'(`TCFG_MILLI);
    return 20'(num / den);
  endfunction
endpackage

// File: tcfg_rate_timer.sv
`include "tcfg_consts.svh"

module tcfg_rate_timer
  import tcfg_pkg::*;
#(
  parameter int unsigned RATE_BASE_CYC = `TCFG_RATE_BASE_CYC
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [7:0] rateCode,
  output logic done
);
  logic [31:0] periodCnt; // Cycles left in the period
  logic [31:0] next_periodCnt;

  // Codes 0..6 double the period per step below the fastest
  function automatic logic [2:0] rateShift(input logic [7:0] code);
    return (code >= `TCFG_RATE_FAST_CODE) ? 3'h0 : 3'(`TCFG_RATE_MAX_SHIFT - code[2:0]);
  endfunction

  // Load period on sequence start, else count down
  always_comb begin
    next_periodCnt = periodCnt;
    if (start) begin
      // rate code to period
      // One less than the period: the start edge itself is the first cycle
      next_periodCnt = (32'(RATE_BASE_CYC) << rateShift(rateCode)) - 32'h1;
    end else if (periodCnt != 32'h0) begin
      next_periodCnt = periodCnt - 32'h1;
    end
  end

  // Period register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      periodCnt <= 32'h0;
    end else begin
      periodCnt <= next_periodCnt;
    end
  end

  assign done = (periodCnt == 32'h0);

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_rate_fast;
    start && rateCode >= `TCFG_RATE_FAST_CODE |=> periodCnt == 32'(RATE_BASE_CYC) - 32'h1;
  endproperty
  a_rate_fast: assert property (p_rate_fast) else $error("fast rate period wrong");

  property p_rate_slowest;
    start && rateCode == 8'h00
      |=> periodCnt == (32'(RATE_BASE_CYC) << `TCFG_RATE_MAX_SHIFT) - 32'h1;
  endproperty
  a_rate_slowest: assert property (p_rate_slowest) else $error("slowest period wrong");
endmodule

// File: tcfg_sensor_model.sv
// Remote sensing transistor front end: answers each detection request
module tcfg_sensor_model
  import tcfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic convDetect,
  input wire logic useDiode,
  input wire logic [2:0] pickRange,
  input wire logic [3:0] delayCyc,
  output logic detValid,
  output logic detDiode,
  output logic [2:0] detRange
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt; // Cycles spent in the current detection
  logic sent; // Answer already given for this detection
  logic [3:0] next_cnt;
  logic next_sent;
  logic next_detValid;
  logic next_detDiode;
  logic [2:0] next_detRange;

  // Next values of the answer logic
  // detection answer
  always_comb begin
    next_cnt = cnt + 4'h1;
    next_sent = sent;
    next_detValid = 1'b0;
    // Result lines toggle outside the answer so stale values never match
    next_detDiode = ~detDiode;
    next_detRange = ~detRange;
    if (!convDetect) begin
      // No request: rearm
      next_cnt = 4'h0;
      next_sent = 1'b0;
    end else if (!sent && cnt == delayCyc) begin
      // Answer after the programmed delay
      next_detValid = 1'b1;
      next_sent = 1'b1;
      next_detDiode = useDiode;
      next_detRange = pickRange;
    end
  end

  // Registers of the answer logic
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 4'h0;
      sent <= 1'b0;
      detValid <= 1'b0;
      detDiode <= 1'b0;
      detRange <= 3'h0;
    end else begin
      cnt <= next_cnt;
      sent <= next_sent;
      detValid <= next_detValid;
      detDiode <= next_detDiode;
      detRange <= next_detRange;
    end
  end
endmodule
